// ===== hdl/arc_pkg.sv
package arc_pkg;

	// Register indices on the plain register port
	localparam logic [3:0] REG_MODE_CTRL = 4'h0;
	localparam logic [3:0] REG_HARDWARE_CONTROL_REG   = 4'h1;
	localparam logic [3:0] REG_STAT      = 4'h2;
	localparam logic [3:0] REG_FAULT     = 4'h3;

	// Mode control register fields
	localparam int BIT_STANDALONE_EN = 0;
	localparam int BIT_LEVEL_SEL     = 1;
	localparam int BIT_UV_INHIBIT    = 2;

	// Hardware control register fields
	localparam int BIT_LS_SELECT     = 0;
	localparam int BIT_LS_STOP_KEEP  = 1;

	// Status register fields
	localparam int BIT_ST_OC         = 0;
	localparam int BIT_ST_ON         = 1;
	localparam int BIT_ST_LOCKED     = 2;
	localparam int BIT_ST_LS         = 3;
	localparam int BIT_ST_UV         = 4;
	localparam int BIT_ST_HP         = 5;
	localparam int BIT_ST_LP         = 6;
	localparam int BIT_ST_LEVEL      = 7;

	// Fault register field
	localparam int BIT_FLT_ACCESS    = 0;

	localparam logic [7:0] ZERO8     = 8'h00;

	typedef enum logic [2:0] {
		ARC_MODE_INIT     = 3'b000,
		ARC_MODE_NORMAL   = 3'b001,
		ARC_MODE_STOP     = 3'b010,
		ARC_MODE_SLEEP    = 3'b011,
		ARC_MODE_RESTART  = 3'b100,
		ARC_MODE_FAILSAFE = 3'b101
	} arc_mode_t;

	typedef enum logic [1:0] {
		ARC_CFG_NONE  = 2'b00,
		ARC_CFG_ALONE = 2'b01,
		ARC_CFG_SHARE = 2'b10
	} arc_cfg_t;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} arc_req_t;

	// Analog stage controls driven to the regulator
	typedef struct packed {
		logic enable;
		logic hp_stage;
		logic lp_stage;
		logic level_3v3;
	} arc_drive_t;

endpackage

// ===== hdl/arc_sync.sv
`timescale 1ns/1ns
module arc_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             i_clk,    // System clock
	input  wire logic             i_rst_n,  // Async reset, active low
	input  wire logic [WIDTH-1:0] i_async,  // Raw pin levels
	output logic      [WIDTH-1:0] o_level   // Filtered levels
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= '0;
			s2   <= '0;
			s3   <= '0;
		end else begin
			meta <= i_async;
			s2   <= meta;
			s3   <= s2;
		end
	end

	// Change taken only once second and third stage agree
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_level <= '0;
		end else begin
			for (int k = 0; k < WIDTH; k++) begin
				if (s2[k] == s3[k]) begin
					o_level[k] <= s3[k];
				end
			end
		end
	end
endmodule

// ===== hdl/arc_ctrl.sv
`timescale 1ns/1ns
//Function
// - Standalone enable written in Normal mode selects standalone configuration.
// - Load-share select bit written selects load-sharing configuration.
// - First configuration bit set locks the choice; later changes ignored.
// - Lock survives soft reset; cleared only by power-on reset.
// - Standalone: level select 0 gives 5.0V, 1 gives 3.3V.
// - Load sharing ignores level select; follows main supply level.
// - Off in Init/Fail-Safe; standalone holds state outside Normal mode.
// - Load sharing follows main supply: off Sleep, on in Restart.
// - Stop mode disables load sharing by default; resumes in Normal.
// - Stop-keep bit with load sharing keeps supply on in Stop.
// - Stop: low-power stage; high-power stage by base current hysteresis.
// - Normal mode runs only the high-power stage.
// - Undervoltage switches off; auto restart unless inhibit bit set.
// - Status flags readable in the supply status register.
// - Change after load-share lock sets access fault, config unchanged.
// - Standalone lock: on/off still allowed, no access fault.
// - Standalone overcurrent sets only its flag; clear once condition gone.
module arc_ctrl (
	input  wire logic                I_SYS_CLK,      // System clock, 25 MHz
	input  wire logic                I_RESET_N,      // Soft/core reset, active low
	input  wire logic                I_POR_N,        // Power-on reset, active low
	input  wire arc_pkg::arc_req_t   I_REQ,          // Register request
	output logic      [7:0]          O_RDATA,        // Read data, cycle after read
	input  wire arc_pkg::arc_mode_t  I_MODE,         // Device operating mode
	input  wire logic                I_MAIN_ON,      // Main supply regulating
	input  wire logic                I_BAT_UV,       // Battery undervoltage pin
	input  wire logic                I_BASE_HI,      // Base current above rising level
	input  wire logic                I_BASE_LO,      // Base current below falling level
	input  wire logic                I_SHUNT_LIM,    // Shunt current limit reached
	output arc_pkg::arc_drive_t      O_DRIVE         // Regulator stage controls
);
	logic [2:0]         pin_lvl;
	logic               uv;
	logic               base_hi;
	logic               base_lo;
	logic               shunt_lim;
	arc_pkg::arc_cfg_t  cfg;
	arc_pkg::arc_cfg_t  next_cfg;
	logic               ls_stop_keep;
	logic               sw_on;
	logic               level_sel;
	logic               uv_inhibit;
	logic               uv_latched_off;
	logic               oc_flag;
	logic               access_fault;
	logic               hp_on;
	logic               lp_on;
	logic               supply_on;
	logic               change_try;
	logic               wr_mode;
	logic               wr_hw;
	logic               wr_stat;
	logic               wr_fault;
	logic               wr_alone_bit;
	logic               wr_ls_bit;
	arc_pkg::arc_drive_t next_drive;

	arc_sync #(
		.WIDTH(3)
	) u_sync (
		.i_clk   (I_SYS_CLK),
		.i_rst_n (I_RESET_N),
		.i_async ({I_BAT_UV, I_SHUNT_LIM, I_BASE_HI}),
		.o_level (pin_lvl)
	);

	assign uv        = pin_lvl[2];
	assign shunt_lim = pin_lvl[1];
	assign base_hi   = pin_lvl[0];

	// Falling comparator is slow-moving; three flops, same filter
	arc_sync #(
		.WIDTH(1)
	) u_sync_lo (
		.i_clk   (I_SYS_CLK),
		.i_rst_n (I_RESET_N),
		.i_async (I_BASE_LO),
		.o_level (base_lo)
	);

	function automatic logic hits(input arc_pkg::arc_req_t r, input logic [3:0] a);
		hits = r.wr && (r.addr == a);
	endfunction

	// Decodes shared by several processes
	function automatic logic is_share(input arc_pkg::arc_cfg_t c);
		is_share = (c == arc_pkg::ARC_CFG_SHARE);
	endfunction

	function automatic logic is_alone(input arc_pkg::arc_cfg_t c);
		is_alone = (c == arc_pkg::ARC_CFG_ALONE);
	endfunction

	function automatic logic is_normal(input arc_pkg::arc_mode_t m);
		is_normal = (m == arc_pkg::ARC_MODE_NORMAL);
	endfunction

	function automatic logic is_stop(input arc_pkg::arc_mode_t m);
		is_stop = (m == arc_pkg::ARC_MODE_STOP);
	endfunction

	assign wr_mode      = hits(I_REQ, arc_pkg::REG_MODE_CTRL);
	assign wr_hw        = hits(I_REQ, arc_pkg::REG_HARDWARE_CONTROL_REG);
	assign wr_stat      = hits(I_REQ, arc_pkg::REG_STAT);
	assign wr_fault     = hits(I_REQ, arc_pkg::REG_FAULT);
	assign wr_alone_bit = wr_mode && I_REQ.wdata[arc_pkg::BIT_STANDALONE_EN];
	assign wr_ls_bit    = wr_hw && I_REQ.wdata[arc_pkg::BIT_LS_SELECT];

	// Configuration choice, only once per power-up
	always_comb begin
		next_cfg = cfg;
		if (cfg == arc_pkg::ARC_CFG_NONE) begin
			if (wr_ls_bit) begin
				next_cfg = arc_pkg::ARC_CFG_SHARE;
			end else if (wr_alone_bit && is_normal(I_MODE)) begin
				next_cfg = arc_pkg::ARC_CFG_ALONE;
			end
		end
	end

	// Lock held across soft reset, cleared by power-on only
	always_ff @(posedge I_SYS_CLK or negedge I_POR_N) begin
		if (!I_POR_N) begin
			cfg <= arc_pkg::ARC_CFG_NONE;
		end else begin
			cfg <= next_cfg;
		end
	end

	// Writable control bits
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			sw_on        <= 1'b0;
			level_sel    <= 1'b0;
			uv_inhibit   <= 1'b0;
			ls_stop_keep <= 1'b0;
		end else begin
			if (wr_mode && is_normal(I_MODE)) begin
				// Standalone supply on/off changeable only in Normal
				if (is_alone(next_cfg)) begin
					sw_on <= I_REQ.wdata[arc_pkg::BIT_STANDALONE_EN];
				end
				if (!is_share(cfg)) begin
					level_sel <= I_REQ.wdata[arc_pkg::BIT_LEVEL_SEL];
				end
			end
			if (wr_mode) begin
				uv_inhibit <= I_REQ.wdata[arc_pkg::BIT_UV_INHIBIT];
			end
			if (wr_hw) begin
				ls_stop_keep <= I_REQ.wdata[arc_pkg::BIT_LS_STOP_KEEP];
			end
		end
	end

	// Any write that would alter a locked configuration
	assign change_try = wr_alone_bit
		|| (wr_hw && !I_REQ.wdata[arc_pkg::BIT_LS_SELECT])
		|| (wr_mode && I_REQ.wdata[arc_pkg::BIT_LEVEL_SEL] != level_sel);

	// Access fault: set wins over clear
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			access_fault <= 1'b0;
		end else if (is_share(cfg) && change_try) begin
			access_fault <= 1'b1;
		end else if (wr_fault && I_REQ.wdata[arc_pkg::BIT_FLT_ACCESS]) begin
			access_fault <= 1'b0;
		end
	end

	// Overcurrent flag, standalone only; clear refused while limit persists
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			oc_flag <= 1'b0;
		end else if (is_alone(cfg) && supply_on && shunt_lim) begin
			oc_flag <= 1'b1;
		end else if (wr_stat && I_REQ.wdata[arc_pkg::BIT_ST_OC]) begin
			oc_flag <= 1'b0;
		end
	end

	// Undervoltage shutdown and restart inhibit
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			uv_latched_off <= 1'b0;
		end else if (uv && uv_inhibit) begin
			uv_latched_off <= 1'b1;
		end else if (wr_mode && I_REQ.wdata[arc_pkg::BIT_STANDALONE_EN] && !uv) begin
			uv_latched_off <= 1'b0;
		end
	end

	// Supply on/off by mode and configuration
	always_comb begin
		supply_on = 1'b0;
		case (I_MODE)
			arc_pkg::ARC_MODE_INIT,
			arc_pkg::ARC_MODE_FAILSAFE: begin
				supply_on = 1'b0;
			end
			arc_pkg::ARC_MODE_NORMAL: begin
				supply_on = (cfg == arc_pkg::ARC_CFG_SHARE) ? I_MAIN_ON : sw_on;
			end
			arc_pkg::ARC_MODE_STOP: begin
				if (cfg == arc_pkg::ARC_CFG_SHARE) begin
					supply_on = ls_stop_keep && I_MAIN_ON;
				end else begin
					supply_on = sw_on;
				end
			end
			arc_pkg::ARC_MODE_SLEEP: begin
				supply_on = (cfg == arc_pkg::ARC_CFG_ALONE) && sw_on;
			end
			arc_pkg::ARC_MODE_RESTART: begin
				if (cfg == arc_pkg::ARC_CFG_SHARE) begin
					supply_on = 1'b1;
				end else begin
					supply_on = sw_on;
				end
			end
			default: begin
				supply_on = 1'b0;
			end
		endcase
		if (cfg == arc_pkg::ARC_CFG_NONE || uv || uv_latched_off) begin
			supply_on = 1'b0;
		end
	end

	// High-power stage hysteresis in Stop mode
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			hp_on <= 1'b0;
		end else if (!is_stop(I_MODE)) begin
			hp_on <= 1'b0;
		end else if (base_hi) begin
			hp_on <= 1'b1;
		end else if (base_lo) begin
			hp_on <= 1'b0;
		end
	end

	always_comb begin
		next_drive.enable    = supply_on;
		next_drive.level_3v3 = is_alone(cfg) && level_sel;
		if (is_stop(I_MODE)) begin
			lp_on               = supply_on;
			next_drive.hp_stage = supply_on && hp_on;
		end else begin
			lp_on               = 1'b0;
			next_drive.hp_stage = supply_on;
		end
		next_drive.lp_stage = lp_on;
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_DRIVE <= '0;
		end else begin
			O_DRIVE <= next_drive;
		end
	end

	// Read data, valid only the cycle after the read strobe
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_RDATA <= arc_pkg::ZERO8;
		end else if (I_REQ.rd) begin
			O_RDATA <= arc_pkg::ZERO8;
			case (I_REQ.addr)
				arc_pkg::REG_MODE_CTRL: begin
					O_RDATA[arc_pkg::BIT_STANDALONE_EN] <= sw_on;
					O_RDATA[arc_pkg::BIT_LEVEL_SEL]     <= level_sel;
					O_RDATA[arc_pkg::BIT_UV_INHIBIT]    <= uv_inhibit;
				end
				arc_pkg::REG_HARDWARE_CONTROL_REG: begin
					O_RDATA[arc_pkg::BIT_LS_SELECT]     <= (cfg == arc_pkg::ARC_CFG_SHARE);
					O_RDATA[arc_pkg::BIT_LS_STOP_KEEP]  <= ls_stop_keep;
				end
				arc_pkg::REG_STAT: begin
					O_RDATA[arc_pkg::BIT_ST_OC]     <= oc_flag;
					O_RDATA[arc_pkg::BIT_ST_ON]     <= O_DRIVE.enable;
					O_RDATA[arc_pkg::BIT_ST_LOCKED] <= (cfg != arc_pkg::ARC_CFG_NONE);
					O_RDATA[arc_pkg::BIT_ST_LS]     <= (cfg == arc_pkg::ARC_CFG_SHARE);
					O_RDATA[arc_pkg::BIT_ST_UV]     <= uv && is_alone(cfg);
					O_RDATA[arc_pkg::BIT_ST_HP]     <= O_DRIVE.hp_stage;
					O_RDATA[arc_pkg::BIT_ST_LP]     <= O_DRIVE.lp_stage;
					O_RDATA[arc_pkg::BIT_ST_LEVEL]  <= O_DRIVE.level_3v3;
				end
				arc_pkg::REG_FAULT: begin
					O_RDATA[arc_pkg::BIT_FLT_ACCESS] <= access_fault;
				end
				default: begin
					O_RDATA <= arc_pkg::ZERO8;
				end
			endcase
		end else begin
			O_RDATA <= arc_pkg::ZERO8;
		end
	end
endmodule

// ===== bench/arc_ctrl_monitor.sv
`timescale 1ns/1ns
module arc_ctrl_monitor (
	input wire logic                I_SYS_CLK,   // Clock
	input wire logic                I_RESET_N,   // Reset, active low
	input wire arc_pkg::arc_req_t   I_REQ,       // Request
	input wire logic [7:0]          O_RDATA,     // Read data
	input wire arc_pkg::arc_mode_t  I_MODE,      // Mode
	input wire logic                I_MAIN_ON,   // Main supply on
	input wire logic                I_BAT_UV,    // Undervoltage
	input wire logic                I_BASE_HI,   // Base current high
	input wire logic                I_BASE_LO,   // Base current low
	input wire arc_pkg::arc_drive_t O_DRIVE      // Stage controls
);
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RESET_N);
	a_init_off: assert property (
		(I_MODE == arc_pkg::ARC_MODE_INIT) [*3] |-> !O_DRIVE.enable)
		else $error("supply on in init mode");
	a_failsafe_off: assert property (
		(I_MODE == arc_pkg::ARC_MODE_FAILSAFE) [*3] |-> !O_DRIVE.enable)
		else $error("supply on in fail-safe mode");
	a_normal_no_lp: assert property (
		(I_MODE == arc_pkg::ARC_MODE_NORMAL) [*3] |-> !O_DRIVE.lp_stage)
		else $error("low-power stage on in normal mode");
	a_normal_hp: assert property (
		(I_MODE == arc_pkg::ARC_MODE_NORMAL) [*3] ##0 O_DRIVE.enable |-> O_DRIVE.hp_stage)
		else $error("high-power stage off in normal mode");
	a_stop_lp: assert property (
		(I_MODE == arc_pkg::ARC_MODE_STOP) [*3] ##0 O_DRIVE.enable |-> O_DRIVE.lp_stage)
		else $error("low-power stage off in stop mode");
	a_uv_off: assert property (
		I_BAT_UV [*8] |-> !O_DRIVE.enable)
		else $error("supply on during undervoltage");
	a_rdata_idle: assert property (
		!$past(I_REQ.rd) |-> O_RDATA == 8'h00)
		else $error("read data outside read answer");
	a_drive_held: assert property (
		($stable(I_MODE) && !I_REQ.wr && $stable(I_MAIN_ON)
		&& $stable(I_BAT_UV) && $stable(I_BASE_HI) && $stable(I_BASE_LO)) [*8]
		|=> $stable(O_DRIVE))
		else $error("drive changed without cause");
	c_normal_on: cover property (I_MODE == arc_pkg::ARC_MODE_NORMAL && O_DRIVE.enable);
	c_stop_both: cover property (O_DRIVE.lp_stage && O_DRIVE.hp_stage);
	c_read: cover property (I_REQ.rd);
endmodule

bind arc_ctrl arc_ctrl_monitor u_mon (.I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N),
	.I_REQ(I_REQ), .O_RDATA(O_RDATA), .I_MODE(I_MODE), .I_MAIN_ON(I_MAIN_ON),
	.I_BAT_UV(I_BAT_UV), .I_BASE_HI(I_BASE_HI), .I_BASE_LO(I_BASE_LO), .O_DRIVE(O_DRIVE));

// ===== bench/arc_pnp_model.sv
`timescale 1ns/1ns
module arc_pnp_model (
	input  wire logic                i_clk,       // Clock
	input  wire arc_pkg::arc_drive_t i_drive,     // Stage controls
	input  wire logic                i_heavy,     // Heavy load
	input  wire logic                i_short,     // Overload
	output logic                     o_base_hi,   // Base above rising level
	output logic                     o_base_lo,   // Base below falling level
	output logic                     o_shunt_lim  // Shunt limit reached
);
	initial begin
		o_base_hi = 1'h0;
		o_base_lo = 1'h1;
		o_shunt_lim = 1'h0;
	end
	always @(posedge i_clk) begin
		o_base_hi <= i_drive.enable && i_heavy;
		o_base_lo <= !(i_drive.enable && i_heavy);
		o_shunt_lim <= i_drive.enable && i_short;
	end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic                clk;
	logic                rst_n;
	logic                por_n;
	arc_pkg::arc_req_t   req;
	logic [7:0]          rdata;
	arc_pkg::arc_mode_t  mode;
	logic                main_on;
	logic                uv;
	logic                b_hi;
	logic                b_lo;
	logic                lim;
	logic                heavy;
	logic                short_c;
	arc_pkg::arc_drive_t drv;
	int                  n_errors;
	int                  samples_checked;

	arc_ctrl dut (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_POR_N(por_n), .I_REQ(req),
		.O_RDATA(rdata), .I_MODE(mode), .I_MAIN_ON(main_on), .I_BAT_UV(uv),
		.I_BASE_HI(b_hi), .I_BASE_LO(b_lo), .I_SHUNT_LIM(lim), .O_DRIVE(drv));
	arc_pnp_model u_pnp (.i_clk(clk), .i_drive(drv), .i_heavy(heavy), .i_short(short_c),
		.o_base_hi(b_hi), .o_base_lo(b_lo), .o_shunt_lim(lim));

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{a, d, 1'h1, 1'h0};
		@(posedge clk);
		req <= '0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		req <= '{a, 8'h00, 1'h0, 1'h1};
		@(posedge clk);
		req <= '0;
		#1;
		chk("rdata", e, rdata & m);
	endtask
	task automatic dv(input logic [3:0] m, input logic [3:0] e);
		repeat (8) @(posedge clk);
		#1;
		chk("drive", {4'h0, e}, {4'h0, drv & m});
	endtask
	task automatic md(input arc_pkg::arc_mode_t m);
		@(posedge clk);
		mode <= m;
	endtask
	task automatic rst(input logic p);
		@(posedge clk);
		rst_n <= 1'h0;
		por_n <= !p;
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		por_n <= 1'h1;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#400000;
		n_errors++;
		test_done();
	end

	initial begin
		{rst_n, por_n, main_on, uv, heavy, short_c} = 6'h08;
		req = '0;
		mode = arc_pkg::ARC_MODE_NORMAL;
		n_errors = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		por_n <= 1'h1;
		wr(arc_pkg::REG_MODE_CTRL, 8'h01);
		dv(4'hF, 4'hC);
		rd(arc_pkg::REG_STAT, 8'h0E, 8'h06);
		wr(arc_pkg::REG_MODE_CTRL, 8'h03);
		dv(4'hF, 4'hD);
		wr(arc_pkg::REG_HARDWARE_CONTROL_REG, 8'h01);
		rd(arc_pkg::REG_STAT, 8'h08, 8'h00);
		rd(arc_pkg::REG_FAULT, 8'h01, 8'h00);
		md(arc_pkg::ARC_MODE_STOP);
		dv(4'hF, 4'hB);
		@(posedge clk) heavy <= 1'h1;
		dv(4'hF, 4'hF);
		rd(arc_pkg::REG_STAT, 8'hE0, 8'hE0);
		@(posedge clk) heavy <= 1'h0;
		dv(4'hF, 4'hB);
		md(arc_pkg::ARC_MODE_SLEEP);
		dv(4'h8, 4'h8);
		md(arc_pkg::ARC_MODE_INIT);
		dv(4'h8, 4'h0);
		md(arc_pkg::ARC_MODE_NORMAL);
		@(posedge clk) short_c <= 1'h1;
		dv(4'hF, 4'hD);
		rd(arc_pkg::REG_STAT, 8'h01, 8'h01);
		wr(arc_pkg::REG_STAT, 8'h01);
		rd(arc_pkg::REG_STAT, 8'h01, 8'h01);
		@(posedge clk) short_c <= 1'h0;
		dv(4'hF, 4'hD);
		wr(arc_pkg::REG_STAT, 8'h01);
		rd(arc_pkg::REG_STAT, 8'h01, 8'h00);
		@(posedge clk) uv <= 1'h1;
		dv(4'h8, 4'h0);
		rd(arc_pkg::REG_STAT, 8'h10, 8'h10);
		@(posedge clk) uv <= 1'h0;
		dv(4'h8, 4'h8);
		wr(arc_pkg::REG_MODE_CTRL, 8'h07);
		rd(arc_pkg::REG_MODE_CTRL, 8'h07, 8'h07);
		@(posedge clk) uv <= 1'h1;
		dv(4'h8, 4'h0);
		@(posedge clk) uv <= 1'h0;
		dv(4'h8, 4'h0);
		$display("standalone test done");
		rst(1'h0);
		wr(arc_pkg::REG_HARDWARE_CONTROL_REG, 8'h01);
		rd(arc_pkg::REG_STAT, 8'h0C, 8'h04);
		rst(1'h1);
		wr(arc_pkg::REG_HARDWARE_CONTROL_REG, 8'h03);
		rd(arc_pkg::REG_STAT, 8'h0C, 8'h0C);
		rd(arc_pkg::REG_HARDWARE_CONTROL_REG, 8'h03, 8'h03);
		wr(arc_pkg::REG_MODE_CTRL, 8'h03);
		rd(arc_pkg::REG_FAULT, 8'h01, 8'h01);
		rd(arc_pkg::REG_STAT, 8'h0C, 8'h0C);
		dv(4'h9, 4'h8);
		@(posedge clk) main_on <= 1'h0;
		dv(4'h8, 4'h0);
		@(posedge clk) main_on <= 1'h1;
		md(arc_pkg::ARC_MODE_STOP);
		dv(4'h8, 4'h8);
		md(arc_pkg::ARC_MODE_SLEEP);
		dv(4'h8, 4'h0);
		md(arc_pkg::ARC_MODE_RESTART);
		dv(4'h8, 4'h8);
		md(arc_pkg::ARC_MODE_FAILSAFE);
		dv(4'h8, 4'h0);
		md(arc_pkg::ARC_MODE_NORMAL);
		wr(arc_pkg::REG_HARDWARE_CONTROL_REG, 8'h01);
		md(arc_pkg::ARC_MODE_STOP);
		dv(4'h8, 4'h0);
		md(arc_pkg::ARC_MODE_NORMAL);
		dv(4'h8, 4'h8);
		wr(arc_pkg::REG_FAULT, 8'h01);
		rd(arc_pkg::REG_FAULT, 8'h01, 8'h00);
		wr(arc_pkg::REG_MODE_CTRL, 8'h02);
		rd(arc_pkg::REG_FAULT, 8'h01, 8'h01);
		wr(arc_pkg::REG_FAULT, 8'h01);
		wr(arc_pkg::REG_HARDWARE_CONTROL_REG, 8'h00);
		rd(arc_pkg::REG_FAULT, 8'h01, 8'h01);
		rd(arc_pkg::REG_STAT, 8'h0C, 8'h0C);
		wr(arc_pkg::REG_FAULT, 8'h01);
		rd(arc_pkg::REG_FAULT, 8'h01, 8'h00);
		rd(4'hF, 8'hFF, 8'h00);
		$display("load share test done");
		test_done();
	end
endmodule
